//--- common/nas_pkg.sv
package nas_pkg;

  // ------------------------------------------------------------------
  // Instruction word layout and codes
  // ------------------------------------------------------------------
  localparam int          OP_MSB       = 15;
  localparam int          OP_LSB       = 11;
  localparam int          ROW_MSB      = 10;
  localparam int          ROW_LSB      = 8;
  localparam int          COL_MSB      = 7;
  localparam int          COL_LSB      = 4;
  localparam int          NIB_MSB      = 3;
  localparam logic [4:0]  OP_ADD_WITH_CARRY_OP_IMM  = 5'h12;
  localparam logic [4:0]  OP_SUB_MEM   = 5'h01;
  localparam logic [4:0]  OP_INC       = 5'h07;
  localparam logic [2:0]  INC_SUBFIELD = 3'h0;
  localparam logic [3:0]  INC_SEL_AR   = 4'h9;
  localparam logic [3:0]  INC_SEL_IX   = 4'h8;
  localparam logic [3:0]  INC_TAIL     = 4'h0;

  // ------------------------------------------------------------------
  // Register port map
  // ------------------------------------------------------------------
  localparam logic [7:0]  REG_PSW      = 8'h00;
  localparam logic [7:0]  REG_RP       = 8'h01;
  localparam logic [7:0]  REG_IX       = 8'h02;
  localparam logic [7:0]  REG_AR       = 8'h03;
  localparam int          MEM_SEL_BIT  = 7;
  localparam int          PSW_Z        = 0;
  localparam int          PSW_CY       = 1;
  localparam int          PSW_CMP      = 2;
  localparam int          PSW_BCD      = 3;
  localparam int          PSW_IXE      = 4;
  localparam int          RP_LOW_LSB   = 0;
  localparam int          RP_HIGH_LSB  = 4;

  // ------------------------------------------------------------------
  // Reset values, widths and arithmetic constants
  // ------------------------------------------------------------------
  localparam logic [4:0]  PSW_RST      = 5'h00;
  localparam logic [3:0]  RPL_RST      = 4'h0;
  localparam logic [2:0]  RPH_RST      = 3'h0;
  localparam logic [11:0] IX_RST       = 12'h000;
  localparam logic [15:0] AR_RST       = 16'h0000;
  localparam logic [15:0] AR_MASK      = 16'h03FF;
  localparam int          DM_DEPTH     = 128;
  localparam logic [3:0]  BCD_MAX      = 4'h9;
  localparam logic [3:0]  BCD_ADJ      = 4'h6;

endpackage : nas_pkg

//--- hdl/nas_nib.sv
`timescale 1ns/1ps
`default_nettype none
module nas_nib
  import nas_pkg::*;
(
  // Operands
  input  wire logic [3:0] a,
  input  wire logic [3:0] b,
  input  wire logic       cin,
  // Mode
  input  wire logic       sub,
  input  wire logic       bcd,
  // Result
  output logic      [3:0] res,
  output logic            cout
);

  logic [4:0] raw_sum;
  logic [4:0] raw_dif;
  logic       sum_ovr;
  logic [3:0] bin_res;
  logic [3:0] dec_res;

  // A decimal sum above nine carries and is corrected by six.
  assign raw_sum = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  assign raw_dif = {1'b0, a} - {1'b0, b} - {4'h0, cin};
  assign sum_ovr = raw_sum[4] | (raw_sum[3:0] > BCD_MAX);

  assign bin_res = sub ? raw_dif[3:0] : raw_sum[3:0];
  assign dec_res = sub ? (raw_dif[4] ? raw_dif[3:0] - BCD_ADJ
                                     : raw_dif[3:0])
                       : (sum_ovr ? raw_sum[3:0] + BCD_ADJ
                                  : raw_sum[3:0]);

  assign res  = bcd ? dec_res : bin_res;
  assign cout = sub ? raw_dif[4]
                    : (bcd ? sum_ovr : raw_sum[4]);

endmodule : nas_nib
`default_nettype wire

//--- hdl/nas_alu.sv
// Notes on behaviour
// - Add-immediate-with-carry decoded from opcode 10010.
// - Compare clear: memory gets nibble plus immediate plus carry.
// - Compare set: memory kept, flags still updated.
// - Addition carry out sets carry, else clears.
// - Nonzero clears zero; zero sets it unless comparing.
// - Zero result while comparing keeps zero flag.
// - Decimal flag picks binary or decimal addition.
// - Table pointer increment decoded, adds one.
// - Table pointer increments as sixteen bits rippling.
// - Table pointer upper six bits read zero.
// - Index pointer increment decoded, adds one.
// - Index pointer increments as twelve bits rippling.
// - Subtract memory from register decoded, opcode 00001.
// - Compare clear: register gets register minus memory.
// - Compare set: register kept, flags still updated.
// - Subtraction borrow sets carry, else clears.
// - Decimal flag picks binary or decimal subtraction.
// - Register pointer selects general register row.
// - Index enable ORs index pointer into address.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module nas_alu
  import nas_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Instruction stream from the core
  input  wire logic [15:0] instr,
  input  wire logic        instr_valid,
  output logic             instr_ack,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Flag view
  output logic             carry_flag,
  output logic             zero_flag
);

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  function automatic logic is_op(input logic [15:0] i,
                                 input logic [4:0]  op);
    is_op = (i[OP_MSB:OP_LSB] == op);
  endfunction : is_op

  function automatic logic is_inc(input logic [15:0] i,
                                  input logic [3:0]  sel);
    is_inc = is_op(i, OP_INC) && (i[ROW_MSB:ROW_LSB] == INC_SUBFIELD)
             && (i[COL_MSB:COL_LSB] == sel) && (i[NIB_MSB:0] == INC_TAIL);
  endfunction : is_inc

  wire add_go = instr_valid && is_op(instr, OP_ADD_WITH_CARRY_OP_IMM);
  wire sub_go = instr_valid && is_op(instr, OP_SUB_MEM);
  wire inc_ar = instr_valid && is_inc(instr, INC_SEL_AR);
  wire inc_ix = instr_valid && is_inc(instr, INC_SEL_IX);
  wire arith  = add_go || sub_go;

  assign instr_ack = add_go || sub_go || inc_ar || inc_ix;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [4:0]  psw_q;
  logic [4:0]  psw_d;
  logic [3:0]  rpl_q;
  logic [3:0]  rpl_d;
  logic [2:0]  rph_q;
  logic [2:0]  rph_d;
  logic [11:0] ix_q;
  logic [11:0] ix_d;
  logic [15:0] ar_q;
  logic [15:0] ar_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [3:0]  mem_q [DM_DEPTH];

  wire cmp = psw_q[PSW_CMP];
  wire cy  = psw_q[PSW_CY];
  wire z   = psw_q[PSW_Z];

  // ------------------------------------------------------------------
  // Operand addressing
  // ------------------------------------------------------------------
  // Only bank 0 is held here, so the pointer high part and the upper
  // index bits do not reach the array; software must keep them at 0.
  wire [6:0] op_addr  = instr[ROW_MSB:COL_LSB];
  wire [6:0] dm_addr  = psw_q[PSW_IXE] ? (op_addr | ix_q[6:0])
                                       : op_addr;
  wire [6:0] gr_addr  = {rpl_q[3:1], instr[NIB_MSB:0]};
  wire [3:0] dm_val   = mem_q[dm_addr];
  wire [3:0] gr_val   = mem_q[gr_addr];
  wire [6:0] dst_addr = add_go ? dm_addr : gr_addr;
  wire [3:0] dst_val  = add_go ? dm_val : gr_val;

  // ------------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------------
  wire [3:0] alu_a   = add_go ? dm_val : gr_val;
  wire [3:0] alu_b   = add_go ? instr[NIB_MSB:0] : dm_val;
  wire       alu_cin = add_go ? cy : 1'b0;
  logic [3:0] alu_res;
  logic       alu_co;

  nas_nib u_nib (
    .a    (alu_a),
    .b    (alu_b),
    .cin  (alu_cin),
    .sub  (sub_go),
    .bcd  (psw_q[PSW_BCD]),
    .res  (alu_res),
    .cout (alu_co)
  );

  wire res_zero = (alu_res == 4'h0);
  wire z_next   = res_zero ? (cmp ? z : 1'b1) : 1'b0;
  wire mem_we   = arith && !cmp;

  // ------------------------------------------------------------------
  // Pointer increment chains
  // ------------------------------------------------------------------
  // Each nibble adds the carry of the one below, as a software chain of
  // add-with-carry steps would.
  logic [4:0]  ar_c;
  logic [15:0] ar_inc;
  logic [3:0]  ix_c;
  logic [11:0] ix_inc;

  assign ar_c[0] = 1'b1;
  assign ix_c[0] = 1'b1;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ar
      assign ar_inc[g*4 +: 4] = ar_q[g*4 +: 4] + {3'h0, ar_c[g]};
      assign ar_c[g+1] = ar_c[g] && (ar_q[g*4 +: 4] == 4'hF);
    end
    for (g = 0; g < 3; g++)
    begin : g_ix
      assign ix_inc[g*4 +: 4] = ix_q[g*4 +: 4] + {3'h0, ix_c[g]};
      assign ix_c[g+1] = ix_c[g] && (ix_q[g*4 +: 4] == 4'hF);
    end
  endgenerate

  // ------------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------------
  wire wr_psw = reg_wr && (reg_addr == REG_PSW);
  wire wr_rp  = reg_wr && (reg_addr == REG_RP);
  wire wr_ix  = reg_wr && (reg_addr == REG_IX);
  wire wr_ar  = reg_wr && (reg_addr == REG_AR);
  wire wr_mem = reg_wr && reg_addr[MEM_SEL_BIT];

  // An instruction update wins over a software write in the same cycle.
  always_comb
  begin
    psw_d = wr_psw ? reg_wdata[4:0] : psw_q;
    if (arith)
    begin
      psw_d[PSW_CY] = alu_co;
      psw_d[PSW_Z]  = z_next;
    end
  end

  assign rpl_d = wr_rp ? reg_wdata[RP_LOW_LSB +: 4] : rpl_q;
  assign rph_d = wr_rp ? reg_wdata[RP_HIGH_LSB +: 3] : rph_q;
  assign ix_d  = inc_ix ? ix_inc : (wr_ix ? reg_wdata[11:0] : ix_q);
  assign ar_d  = (inc_ar ? ar_inc : (wr_ar ? reg_wdata : ar_q))
                 & AR_MASK;

  assign rdata_d = !reg_rd                 ? 16'h0000 :
                   reg_addr[MEM_SEL_BIT]   ? {12'h000, mem_q[reg_addr[6:0]]} :
                   (reg_addr == REG_PSW)   ? {11'h000, psw_q} :
                   (reg_addr == REG_RP)    ? {9'h000, rph_q, rpl_q} :
                   (reg_addr == REG_IX)    ? {4'h0, ix_q} :
                   (reg_addr == REG_AR)    ? ar_q :
                                             16'h0000;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      psw_q   <= PSW_RST;
      rpl_q   <= RPL_RST;
      rph_q   <= RPH_RST;
      ix_q    <= IX_RST;
      ar_q    <= AR_RST;
      rdata_q <= 16'h0000;
    end
    else
    begin
      psw_q   <= psw_d;
      rpl_q   <= rpl_d;
      rph_q   <= rph_d;
      ix_q    <= ix_d;
      ar_q    <= ar_d;
      rdata_q <= rdata_d;
    end
  end

  // The array has no reset; software is expected to clear what it uses.
  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem_q[dst_addr] <= alu_res;
    else if (wr_mem)
      mem_q[reg_addr[6:0]] <= reg_wdata[3:0];
  end

  assign reg_rdata  = rdata_q;
  assign carry_flag = cy;
  assign zero_flag  = z;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_q);

  sequence s_store_add;
    add_go && !cmp;
  endsequence

  sequence s_store_sub;
    sub_go && !cmp;
  endsequence

  sequence s_compare;
    arith && cmp;
  endsequence

  a_add_store: assert property (s_store_add |=>
    mem_q[$past(dst_addr)] == $past(alu_res))
    else $error("Add result not written to memory.");

  a_sub_store: assert property (s_store_sub |=>
    mem_q[$past(dst_addr)] ==
      $past((psw_q[PSW_BCD] && (gr_val < dm_val)) ?
            (gr_val - dm_val - BCD_ADJ) : (gr_val - dm_val)))
    else $error("Difference not written to register.");

  a_cmp_keep: assert property (s_compare ##0 !wr_mem |=>
    mem_q[$past(dst_addr)] == $past(dst_val))
    else $error("Compare changed the destination.");

  a_carry_track: assert property (arith |=>
    carry_flag == $past(alu_co))
    else $error("Carry flag does not follow the result.");

  a_borrow_bin: assert property (sub_go && !psw_q[PSW_BCD] |=>
    carry_flag == ($past(gr_val) < $past(dm_val)))
    else $error("Borrow flag wrong for binary subtract.");

  a_zero_clear: assert property (arith && !res_zero |=>
    !zero_flag)
    else $error("Nonzero result left zero flag set.");

  a_zero_hold: assert property (s_compare ##0 res_zero |=>
    zero_flag == $past(zero_flag))
    else $error("Compare zero result changed zero flag.");

  a_ar_step: assert property (inc_ar |=>
    ar_q == (($past(ar_q) + 16'h0001) & AR_MASK))
    else $error("Table pointer did not step by one.");

  a_ar_upper: assert property ((ar_q & ~AR_MASK) == 16'h0000)
    else $error("Table pointer upper bits not zero.");

  a_ix_step: assert property (inc_ix |=>
    ix_q == $past(ix_q) + 12'h001)
    else $error("Index pointer did not step by one.");

endmodule : nas_alu
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import nas_pkg::*;
;
  // --------------------------------------------------------------
  // Stimulus signals, model state and design hookup
  // --------------------------------------------------------------
  logic        clk         = 1'b0;
  logic        rstn        = 1'b0;
  logic [15:0] instr       = 16'h0000;
  logic        instr_valid = 1'b0;
  logic        instr_ack;
  logic [7:0]  reg_addr    = 8'h00;
  logic [15:0] reg_wdata   = 16'h0000;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [15:0] reg_rdata;
  logic        carry_flag;
  logic        zero_flag;
  int          n_errors    = 0;
  int          tests_run   = 0;
  int          cyc         = 0;
  logic [7:0]  rnd         = 8'h32;
  int          mem [128];

  always #2.5 clk = ~clk;

  nas_alu uut (
    .clk(clk), .rstn(rstn), .instr(instr), .instr_valid(instr_valid),
    .instr_ack(instr_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .carry_flag(carry_flag), .zero_flag(zero_flag));

  // --------------------------------------------------------------
  // Bus, instruction and checking tasks
  // --------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic roll(output logic [31:0] v);
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      v = {v[23:0], rnd};
    end
  endtask : roll

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rdchk

  // Holds the strobe so that bursts run back to back; idle ends them.
  task automatic exec(input logic [15:0] w, input logic ack);
    @(posedge clk);
    instr       <= w;
    instr_valid <= 1'b1;
    #1 chk(16'(instr_ack), 16'(ack));
  endtask : exec

  task automatic idle;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask : idle

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial
  begin
    logic [31:0] v, u;
    logic        sub, bcd, cmp, cy, z, index_enable_flag, c;
    logic [3:0]  regptr_low, col, n4;
    logic [2:0]  row;
    logic [11:0] ix;
    logic [6:0]  ea, ra, dest;
    int          va, vb, a, b, d, md;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(REG_PSW, 16'h0000);
    rdchk(REG_RP, 16'h0000);
    rdchk(REG_IX, 16'h0000);
    rdchk(REG_AR, 16'h0000);
    wr(8'h04, 16'hFFFF);
    rdchk(8'h04, 16'h0000);
    wr(REG_RP, 16'hFFFF);
    rdchk(REG_RP, 16'h007F);
    $display("test registers done");
    wr(REG_AR, 16'hFFFF);
    rdchk(REG_AR, 16'h03FF);
    exec({OP_INC, INC_SUBFIELD, INC_SEL_AR, INC_TAIL}, 1'b1);
    idle();
    rdchk(REG_AR, 16'h0000);
    wr(REG_AR, 16'h00FF);
    exec({OP_INC, INC_SUBFIELD, INC_SEL_AR, INC_TAIL}, 1'b1);
    exec({OP_INC, INC_SUBFIELD, INC_SEL_AR, INC_TAIL}, 1'b1);
    exec({OP_INC, INC_SUBFIELD, INC_SEL_AR, 4'h1}, 1'b0);
    exec(16'h0000, 1'b0);
    idle();
    rdchk(REG_AR, 16'h0101);
    wr(REG_IX, 16'hFFFF);
    exec({OP_INC, INC_SUBFIELD, INC_SEL_IX, INC_TAIL}, 1'b1);
    idle();
    rdchk(REG_IX, 16'h0000);
    wr(REG_IX, 16'h00FE);
    exec({OP_INC, INC_SUBFIELD, INC_SEL_IX, INC_TAIL}, 1'b1);
    exec({OP_INC, INC_SUBFIELD, INC_SEL_IX, INC_TAIL}, 1'b1);
    idle();
    rdchk(REG_IX, 16'h0100);
    $display("test increments done");
    wr(REG_PSW, 16'h0000);
    wr(8'h86, 16'h000F);
    exec({OP_ADD_WITH_CARRY_OP_IMM, 3'h0, 4'h6, 4'h1}, 1'b1);
    exec({OP_ADD_WITH_CARRY_OP_IMM, 3'h0, 4'h6, 4'h0}, 1'b1);
    idle();
    rdchk(8'h86, 16'h0001);
    wr(REG_PSW, 16'h0005);
    wr(8'h85, 16'h0000);
    exec({OP_ADD_WITH_CARRY_OP_IMM, 3'h0, 4'h5, 4'h0}, 1'b1);
    exec({OP_ADD_WITH_CARRY_OP_IMM, 3'h0, 4'h5, 4'hF}, 1'b1);
    chk(16'(zero_flag), 16'h0001);
    exec({OP_ADD_WITH_CARRY_OP_IMM, 3'h0, 4'h5, 4'h0}, 1'b1);
    idle();
    chk(16'(zero_flag), 16'h0000);
    rdchk(8'h85, 16'h0000);
    $display("test chained flags done");
    for (int i = 0; i < 48; i++)
    begin
      roll(v);
      roll(u);
      sub = v[0];
      bcd = v[1];
      cmp = v[2];
      cy  = v[3];
      z   = v[4];
      index_enable_flag = v[5];
      regptr_low = v[9:6];
      row = v[12:10];
      col = v[16:13];
      n4  = v[20:17];
      ix  = u[11:0];
      md  = bcd ? 10 : 16;
      va  = int'(u[15:12]) % md;
      vb  = int'(u[19:16]) % md;
      if (!sub)
        n4 = 4'(int'(n4) % md);
      if (u[21:20] == 2'h0 && sub)
        va = vb;
      if (u[21:20] == 2'h0 && !sub)
        n4 = 4'((md - vb - cy) % md);
      ea = {row, col} | (index_enable_flag ? ix[6:0] : 7'h00);
      ra = {regptr_low[3:1], n4};
      wr(REG_PSW, {11'h000, index_enable_flag, bcd, cmp, cy, z});
      wr(REG_RP, {12'h000, regptr_low});
      wr(REG_IX, {4'h0, ix});
      wr({1'b1, ea}, 16'(vb));
      mem[ea] = vb;
      if (sub)
      begin
        wr({1'b1, ra}, 16'(va));
        mem[ra] = va;
      end
      a = sub ? mem[ra] : mem[ea];
      b = sub ? mem[ea] : int'(n4);
      dest = sub ? ra : ea;
      if (sub)
      begin
        d = a - b;
        c = (d < 0);
        if (bcd && c)
          d = d - 6;
      end
      else
      begin
        d = a + b + cy;
        c = bcd ? (d > 9) : (d > 15);
        if (bcd && c)
          d = d + 6;
      end
      d = d & 15;
      cy = c;
      if (d != 0)
        z = 1'b0;
      else if (!cmp)
        z = 1'b1;
      if (!cmp)
        mem[dest] = d;
      exec({sub ? OP_SUB_MEM : OP_ADD_WITH_CARRY_OP_IMM, row, col, n4}, 1'b1);
      idle();
      chk(16'(carry_flag), 16'(cy));
      chk(16'(zero_flag), 16'(z));
      rdchk({1'b1, dest}, 16'(mem[dest]));
      rdchk(REG_PSW, {11'h000, index_enable_flag, bcd, cmp, cy, z});
    end
    $display("test random arithmetic done");
    report_and_stop();
  end

endmodule : tb_top
`default_nettype wire
